// ---- src/rts_pkg.sv ----
`default_nettype none
package rts_pkg;
	// clock rate of pclk
	localparam int CLK_HZ = 20_000_000;
	// power-up delay, printed as 72 ms
	localparam int POWERUP_DELAY_TIMER_TIME_MS = 72;
	localparam int POWERUP_DELAY_TIMER_CYC = POWERUP_DELAY_TIMER_TIME_MS * (CLK_HZ / 1000);
	// brown-out qualification, a least time, rounded up
	localparam int BOR_QUAL_US = 100;
	localparam int BOR_QUAL_CYC = (BOR_QUAL_US * (CLK_HZ / 1000) + 999) / 1000;
	// master-clear glitch filter, a least time, rounded up
	localparam int MASTER_CLEAR_N_FILT_NS = 200;
	localparam int MASTER_CLEAR_N_FILT_CYC = (MASTER_CLEAR_N_FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// oscillator settle count in edges of the oscillator input
	localparam int OST_CYC = 1024;
	localparam int CNT_W = 21;
	localparam int BQ_W = 12;
	// register byte addresses
	localparam logic [11:0] ADDR_STATUS = 12'h000;
	localparam logic [11:0] ADDR_POWER_RESET_CAUSE = 12'h004;
	localparam logic [11:0] ADDR_SEQ = 12'h008;
	// field positions
	localparam int TO_BIT = 4;
	localparam int PD_BIT = 3;
	localparam int POR_BIT = 1;
	localparam int BORF_BIT = 0;
	// reset values, unknown bits taken as zero
	localparam logic [7:0] STATUS_POR = 8'h18;
	localparam logic [1:0] POWER_RESET_CAUSE_POR = 2'h0;
	localparam logic [2:0] BANK_RST = 3'h0;
	// program counter start values
	localparam int PC_W = 13;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [PC_W-1:0] PC_IRQ_VEC = 13'h0004;
	localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

	typedef enum logic [1:0] {
		RTS_LP = 2'h0,
		RTS_XT = 2'h1,
		RTS_HS = 2'h2,
		RTS_RC = 2'h3
	} rts_osc_mode_t;

	typedef struct packed {
		logic brownout_enable_cfg;
		logic powerup_delay_enable_n;
		rts_osc_mode_t osc_mode;
	} rts_cfg_t;

	// gray order along hold, delay, settle, run
	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_POWERUP_DELAY_TIMER = 2'b01,
		ST_OST = 2'b11,
		ST_RUN = 2'b10
	} rts_state_t;

	// crystal and resonator modes need the settle count
	function automatic logic rts_is_crystal(input rts_osc_mode_t m);
		return m != RTS_RC;
	endfunction : rts_is_crystal
endpackage : rts_pkg
`default_nettype wire

// ---- src/rts_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module rts_sync
	import rts_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// two flops per bit; the first is read only by the second
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				meta_ff[i] <= 1'b0;
				sync_ff[i] <= 1'b0;
			end else begin
				meta_ff[i] <= d[i];
				sync_ff[i] <= meta_ff[i];
			end
		end
	end

	assign q = sync_ff;
endmodule : rts_sync
`default_nettype wire

// ---- src/rts_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module rts_timer
	import rts_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic step,
	input wire logic [CNT_W-1:0] limit,
	output logic done
);
	logic [CNT_W-1:0] count_ff;

	// saturating up-count; clear has priority so a source holds it at zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_ff <= '0;
		end else if (clr) begin
			count_ff <= '0;
		end else if (step && count_ff != limit) begin
			count_ff <= count_ff + 1'b1;
		end
	end

	assign done = (count_ff == limit);
endmodule : rts_timer
`default_nettype wire

// ---- src/rts_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
// Contract
// - hold reset for 1024 oscillator edges
// - settle count only in crystal modes
// - brown-out reset only when configured on
// - brown-out needs low supply beyond qualify time
// - stay in reset, then power-up delay
// - low again during delay restarts sequence
// - brown-out enable forces power-up delay on
// - delay, then settle count, then release
// - master clear held past time-outs starts immediately
// - delay selection by mode and cause
// - brown-out flag cleared on brown-out, software sets
// - power-on flag cleared only by power-on
// - timeout and powerdown flags encode cause
// - status and power flags reset values
// - start address zero, next, or vector
// - power-on and brown-out initialise registers
// - power-up delay of 72 ms
// - never drive clear pin, filter glitches
module rts_sequencer
	import rts_pkg::*;
#(
	parameter int POWERUP_DELAY_TIMER_CYC_P = POWERUP_DELAY_TIMER_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire rts_cfg_t cfg,
	input wire logic master_clear_n,
	input wire logic por_detect,
	input wire logic brownout_low,
	input wire logic oscillator_input,
	input wire logic watchdog_timeout,
	input wire logic sleep_enter,
	input wire logic irq_wake_req,
	input wire logic global_irq_enable,
	input wire logic [PC_W-1:0] pc_current,
	output logic core_hold,
	output logic periph_reset,
	output logic [PC_W-1:0] pc_start
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic master_clear_n_n_s;
	logic por_s;
	logic bor_low_s;
	logic osc_s;
	logic osc_prev_ff;
	logic osc_rise;
	logic master_clear_n_low;
	logic master_clear_n_low_prev_ff;
	logic master_clear_n_evt;
	logic bor_qual;
	logic bor_hold_ff;
	logic hold_src;
	logic powerup_delay_timer_done;
	logic ost_done;
	logic xtal;
	logic powerup_delay_timer_need;
	logic sleep_ff;
	logic wake_seq_ff;
	logic wdt_reset;
	logic wdt_wake;
	logic irq_wake;
	logic wake;
	logic [BQ_W-1:0] low_run_ff;
	rts_state_t state_ff;
	rts_state_t nxt_state;
	logic [7:0] status_ff;
	logic [7:0] nxt_status;
	logic [1:0] power_reset_cause_ff;
	logic [1:0] nxt_power_reset_cause;
	logic [31:0] rd_mux;
	logic pready_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic core_hold_ff;
	logic periph_reset_ff;
	logic [PC_W-1:0] pc_start_ff;
	logic acc;
	logic wr_fire;

	// address match, shared by the read mux, the error check and writes
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction : hit

	rts_sync #(.W(4)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({master_clear_n, por_detect, brownout_low, oscillator_input}),
		.q({master_clear_n_n_s, por_s, bor_low_s, osc_s})
	);

	// oscillator edges are counted on the synchronised copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_prev_ff <= 1'b0;
		end else begin
			osc_prev_ff <= osc_s;
		end
	end
	assign osc_rise = osc_s & ~osc_prev_ff;

	// short low pulses on the clear pin never count
	rts_timer u_master_clear_n_filt (
		.clk(pclk),
		.rst_n(presetn),
		.clr(master_clear_n_n_s),
		.step(1'b1),
		.limit(CNT_W'(MASTER_CLEAR_N_FILT_CYC)),
		.done(master_clear_n_low)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_clear_n_low_prev_ff <= 1'b0;
		end else begin
			master_clear_n_low_prev_ff <= master_clear_n_low;
		end
	end
	assign master_clear_n_evt = master_clear_n_low & ~master_clear_n_low_prev_ff;

	// qualify timer only runs when brown-out is enabled
	// low supply must persist for the qualify time
	rts_timer u_bor_qual (
		.clk(pclk),
		.rst_n(presetn),
		.clr(~(bor_low_s & cfg.brownout_enable_cfg)),
		.step(1'b1),
		.limit(CNT_W'(BOR_QUAL_CYC)),
		.done(bor_qual)
	);

	// brown-out held until the supply indication recovers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bor_hold_ff <= 1'b0;
		end else if (!cfg.brownout_enable_cfg) begin
			bor_hold_ff <= 1'b0;
		end else if (bor_qual) begin
			bor_hold_ff <= 1'b1;
		end else if (!bor_low_s) begin
			bor_hold_ff <= 1'b0;
		end
	end

	// run length of low supply, kept only to check qualification
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_run_ff <= '0;
		end else if (!(bor_low_s && cfg.brownout_enable_cfg)) begin
			low_run_ff <= '0;
		end else if (low_run_ff != BQ_W'(BOR_QUAL_CYC)) begin
			low_run_ff <= low_run_ff + 1'b1;
		end
	end

	// power sources hold the sequence in its idle state
	assign hold_src = por_s | bor_hold_ff;
	// brown-out enable forces the delay on
	assign powerup_delay_timer_need = ~cfg.powerup_delay_enable_n | cfg.brownout_enable_cfg;
	// settle count skipped in RC mode
	assign xtal = rts_is_crystal(cfg.osc_mode);

	// fixed delay timed from the local clock
	rts_timer u_powerup_delay_timer (
		.clk(pclk),
		.rst_n(presetn),
		.clr(state_ff != ST_POWERUP_DELAY_TIMER),
		.step(1'b1),
		.limit(CNT_W'(POWERUP_DELAY_TIMER_CYC_P)),
		.done(powerup_delay_timer_done)
	);

	rts_timer u_ost (
		.clk(pclk),
		.rst_n(presetn),
		.clr(state_ff != ST_OST),
		.step(osc_rise),
		.limit(CNT_W'(OST_CYC)),
		.done(ost_done)
	);

	// watchdog and wake events split by the sleep state
	assign wdt_reset = watchdog_timeout & ~sleep_ff;
	assign wdt_wake = watchdog_timeout & sleep_ff;
	assign irq_wake = irq_wake_req & sleep_ff;
	assign wake = wdt_wake | irq_wake;

	// delay, then settle count, then run
	// each cause picks its own chain of time-outs
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_HOLD: begin
				nxt_state = powerup_delay_timer_need ? ST_POWERUP_DELAY_TIMER : (xtal ? ST_OST : ST_RUN);
			end
			ST_POWERUP_DELAY_TIMER: begin
				if (powerup_delay_timer_done) begin
					nxt_state = xtal ? ST_OST : ST_RUN;
				end
			end
			ST_OST: begin
				if (ost_done) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (wake && xtal) begin
					nxt_state = ST_OST;
				end
			end
		endcase
		// low supply during the delay starts over
		if (hold_src) begin
			nxt_state = ST_HOLD;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_HOLD;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// sleep tracking; any reset or wake ends it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_ff <= 1'b0;
		end else if (hold_src || master_clear_n_low || wake) begin
			sleep_ff <= 1'b0;
		end else if (sleep_enter) begin
			sleep_ff <= 1'b1;
		end
	end

	// a wake keeps registers, so its settle count must not init them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_seq_ff <= 1'b0;
		end else if (hold_src || master_clear_n_low) begin
			wake_seq_ff <= 1'b0;
		end else if (wake) begin
			wake_seq_ff <= 1'b1;
		end
	end

	// clear pin gates only the last step, timers keep running
	// nothing here drives the clear pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_hold_ff <= 1'b1;
		end else begin
			core_hold_ff <= (nxt_state != ST_RUN) | master_clear_n_low | wdt_reset;
		end
	end

	// register init on every reset except a wake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_reset_ff <= 1'b1;
		end else begin
			periph_reset_ff <= ((nxt_state != ST_RUN) & ~wake_seq_ff & ~wake) | master_clear_n_low | wdt_reset;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_start_ff <= PC_RESET;
		end else if (hold_src || master_clear_n_low || wdt_reset) begin
			pc_start_ff <= PC_RESET;
		end else if (irq_wake && global_irq_enable) begin
			pc_start_ff <= PC_IRQ_VEC;
		end else if (wake) begin
			pc_start_ff <= pc_current + PC_STEP;
		end
	end

	// apb access phase and the edge at which a write lands
	assign acc = psel & penable;
	assign wr_fire = acc & pready_ff & pwrite;

	// cause flags; hardware events beat a software write
	always_comb begin
		nxt_status = status_ff;
		if (wr_fire && hit(paddr, ADDR_STATUS)) begin
			nxt_status = {pwdata[7:5], status_ff[TO_BIT], status_ff[PD_BIT], pwdata[2:0]};
		end
		if (sleep_enter && !sleep_ff) begin
			nxt_status[TO_BIT] = 1'b1;
			nxt_status[PD_BIT] = 1'b0;
		end
		if (wdt_reset) begin
			nxt_status[7:5] = BANK_RST;
			nxt_status[TO_BIT] = 1'b0;
			nxt_status[PD_BIT] = 1'b1;
		end
		if (wdt_wake) begin
			nxt_status[TO_BIT] = 1'b0;
			nxt_status[PD_BIT] = 1'b0;
		end
		if (irq_wake) begin
			nxt_status[TO_BIT] = 1'b1;
			nxt_status[PD_BIT] = 1'b0;
		end
		if (master_clear_n_evt) begin
			nxt_status[7:5] = BANK_RST;
			if (sleep_ff) begin
				nxt_status[TO_BIT] = 1'b1;
				nxt_status[PD_BIT] = 1'b0;
			end
		end
		if (bor_hold_ff) begin
			nxt_status[7:5] = BANK_RST;
			nxt_status[TO_BIT] = 1'b1;
			nxt_status[PD_BIT] = 1'b1;
		end
		if (por_s) begin
			nxt_status = STATUS_POR;
		end
	end

	// brown-out flag cleared by hardware, set by software
	// power-on flag written by software, cleared by hardware only on power-on
	always_comb begin
		nxt_power_reset_cause = power_reset_cause_ff;
		if (wr_fire && hit(paddr, ADDR_POWER_RESET_CAUSE)) begin
			nxt_power_reset_cause = pwdata[1:0];
		end
		if (bor_hold_ff) begin
			nxt_power_reset_cause[BORF_BIT] = 1'b0;
		end
		if (por_s) begin
			nxt_power_reset_cause = POWER_RESET_CAUSE_POR;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= STATUS_POR;
			power_reset_cause_ff <= POWER_RESET_CAUSE_POR;
		end else begin
			status_ff <= nxt_status;
			power_reset_cause_ff <= nxt_power_reset_cause;
		end
	end

	// read mux, unmapped reads return zero
	always_comb begin
		rd_mux = '0;
		if (hit(paddr, ADDR_STATUS)) begin
			rd_mux[7:0] = status_ff;
		end else if (hit(paddr, ADDR_POWER_RESET_CAUSE)) begin
			rd_mux[1:0] = power_reset_cause_ff;
		end else if (hit(paddr, ADDR_SEQ)) begin
			rd_mux[4:0] = {state_ff, sleep_ff, wake_seq_ff, bor_hold_ff};
		end
	end

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			prdata_ff <= '0;
			pslverr_ff <= 1'b0;
		end else if (acc && !pready_ff) begin
			pready_ff <= 1'b1;
			prdata_ff <= pwrite ? '0 : rd_mux;
			pslverr_ff <= ~(hit(paddr, ADDR_STATUS) | hit(paddr, ADDR_POWER_RESET_CAUSE) | hit(paddr, ADDR_SEQ));
		end else begin
			pready_ff <= 1'b0;
			prdata_ff <= '0;
			pslverr_ff <= 1'b0;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign core_hold = core_hold_ff;
	assign periph_reset = periph_reset_ff;
	assign pc_start = pc_start_ff;

	// settle count must be complete when run begins
	ost_full_a: assert property (($past(state_ff) == ST_OST && state_ff == ST_RUN) |-> ost_done)
		else $error("settle count left early");
	// settle state never seen in RC mode
	rc_no_ost_a: assert property ((state_ff == ST_OST && $past(cfg) == cfg) |-> xtal)
		else $error("settle count in RC mode");
	// disabled detector never raises a brown-out
	bor_off_a: assert property ((!cfg.brownout_enable_cfg && !$past(cfg.brownout_enable_cfg)) |-> !$rose(bor_hold_ff))
		else $error("brown-out while disabled");
	// brown-out only after the full qualify time
	bor_qual_a: assert property ($rose(bor_hold_ff) |-> $past(low_run_ff) == BQ_W'(BOR_QUAL_CYC))
		else $error("brown-out not qualified");
	// recovery enters the power-up delay next
	bor_recover_a: assert property (($fell(bor_hold_ff) && !por_s && cfg.brownout_enable_cfg) |=> state_ff == ST_POWERUP_DELAY_TIMER)
		else $error("no delay after brown-out");
	// low again during delay returns to hold
	bor_restart_a: assert property ((state_ff == ST_POWERUP_DELAY_TIMER && bor_hold_ff) |=> state_ff == ST_HOLD)
		else $error("delay not restarted");
	// leaving hold with brown-out on always takes the delay
	powerup_delay_timer_forced_a: assert property (($past(state_ff) == ST_HOLD && state_ff != ST_HOLD
		&& $past(cfg.brownout_enable_cfg)) |-> state_ff == ST_POWERUP_DELAY_TIMER)
		else $error("delay skipped with brown-out on");
	// released pin starts the core at once once time-outs end
	master_clear_n_go_a: assert property ((state_ff == ST_RUN && nxt_state == ST_RUN && !master_clear_n_low && !wdt_reset)
		|=> !core_hold_ff)
		else $error("core not released");
	// counters held cleared two cycles into a source
	hold_clear_a: assert property ((hold_src ##1 hold_src) |-> ##1 (!powerup_delay_timer_done && !ost_done))
		else $error("counter ran under a source");
	// power-on clears the power-on flag
	por_flag_a: assert property (por_s |=> !power_reset_cause_ff[POR_BIT] && status_ff == STATUS_POR)
		else $error("power-on flags wrong");
	// watchdog reset in run gives timeout 0, powerdown 1
	wdt_cause_a: assert property ((wdt_reset && !hold_src && !master_clear_n_evt)
		|=> (!status_ff[TO_BIT] && status_ff[PD_BIT]))
		else $error("watchdog cause wrong");
	// interrupt wake with global enable loads the vector
	pc_vec_a: assert property ((irq_wake && global_irq_enable && !hold_src && !master_clear_n_low)
		|=> pc_start_ff == PC_IRQ_VEC)
		else $error("vector not loaded");

	full_seq_c: cover property ($past(state_ff) == ST_OST && state_ff == ST_RUN && !wake_seq_ff);
	bor_seq_c: cover property ($fell(bor_hold_ff) ##[1:300] state_ff == ST_POWERUP_DELAY_TIMER);
	wake_irq_c: cover property (irq_wake && global_irq_enable);
	master_clear_n_held_c: cover property (state_ff == ST_RUN && master_clear_n_low ##1 !master_clear_n_low);
endmodule : rts_sequencer
`default_nettype wire

// ---- testbench/rts_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none
module rts_far_side (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr_req,
	input wire logic low_req,
	input wire logic por_req,
	output logic master_clear_n,
	output logic por_detect,
	output logic brownout_low,
	output logic oscillator_input
);
	logic [1:0] osc_cnt_ff;

	// crystal model at a quarter of pclk, slow enough that every edge is seen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_cnt_ff <= 2'h0;
		end else begin
			osc_cnt_ff <= osc_cnt_ff + 2'h1;
		end
	end
	assign oscillator_input = osc_cnt_ff[1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_clear_n <= 1'h1;
			por_detect <= 1'h0;
			brownout_low <= 1'h0;
		end else begin
			master_clear_n <= !clr_req;
			por_detect <= por_req;
			brownout_low <= low_req;
		end
	end
endmodule : rts_far_side
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
	import rts_pkg::*;
;
	// short delay keeps the run small; brown-out must still qualify inside it
	localparam int PW = 2500;
	localparam int OSC = 4 * OST_CYC;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, master_clear_n, por_detect, brownout_low, oscillator_input;
	logic core_hold, periph_reset;
	logic watchdog_timeout, sleep_enter, irq_wake_req;
	logic [2:0] ev = 3'h0;
	logic global_irq_enable = 1'h0;
	logic clr_req = 1'h0;
	logic low_req = 1'h0;
	logic por_req = 1'h0;
	logic [PC_W-1:0] pc_current = 13'h0123;
	logic [PC_W-1:0] pc_start;
	rts_cfg_t cfg = '{1'h0, 1'h0, RTS_XT};
	int err_count = 0;
	int cmp_count = 0;
	int n;

	always #25 pclk = ~pclk;
	// one-cycle core events share one driver
	assign watchdog_timeout = ev[0];
	assign sleep_enter = ev[1];
	assign irq_wake_req = ev[2];

	rts_far_side far_u (.pclk(pclk), .presetn(presetn), .clr_req(clr_req), .low_req(low_req),
		.por_req(por_req), .master_clear_n(master_clear_n), .por_detect(por_detect),
		.brownout_low(brownout_low), .oscillator_input(oscillator_input));

	rts_sequencer #(.POWERUP_DELAY_TIMER_CYC_P(PW)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cfg(cfg), .master_clear_n(master_clear_n),
		.por_detect(por_detect), .brownout_low(brownout_low), .oscillator_input(oscillator_input),
		.watchdog_timeout(watchdog_timeout), .sleep_enter(sleep_enter), .irq_wake_req(irq_wake_req),
		.global_irq_enable(global_irq_enable), .pc_current(pc_current), .core_hold(core_hold),
		.periph_reset(periph_reset), .pc_start(pc_start));

	task automatic print_verdict();
		$display("compares %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		cmp_count++;
		if (got !== ex) begin
			err_count++;
			$display("Error %s expected %0h seen %0h", nm, ex, got);
		end
	endtask : chk

	task automatic rng(input string nm, input int lo, input int hi, input int got);
		cmp_count++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("Error %s expected %0d to %0d seen %0d", nm, lo, hi, got);
		end
	endtask : rng

	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask : tick

	// request held until pready is sampled high, released after that edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int w;
		w = 0;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1 && w < 50) begin
			@(posedge pclk);
			w++;
		end
		if (w >= 50) begin
			err_count++;
			$display("Error apb pready expected 1 seen timeout");
		end
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
		logic [31:0] r;
		logic e;
		apb(1'h0, a, 32'h0, r, e);
		chk(nm, ex, r);
	endtask : rd

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'h1, a, d, r, e);
	endtask : wr

	task automatic pulse(input logic [2:0] k);
		ev <= k;
		@(posedge pclk);
		ev <= 3'h0;
		tick(8);
	endtask : pulse

	task automatic rel(output int c);
		c = 0;
		while (core_hold !== 1'h0 && c < 20000) begin
			@(posedge pclk);
			c++;
		end
		if (c >= 20000) begin
			err_count++;
			$display("Error core_hold release expected 0 seen timeout");
		end
	endtask : rel

	// counts cycles where the hold differs from the level expected
	task automatic stay(input int k, input logic v, input string nm);
		int bad;
		bad = 0;
		repeat (k) begin
			@(posedge pclk);
			if (core_hold !== v) bad++;
		end
		chk(nm, 32'h0, bad);
	endtask : stay

	task automatic por(input rts_osc_mode_t m, input logic en_n, input logic bo);
		cfg <= '{bo, en_n, m};
		por_req <= 1'h1;
		tick(2);
		por_req <= 1'h0;
		// far-side flop plus two sync flops: wait until the hold is visible
		tick(5);
	endtask : por

	task automatic t_power_on();
		rd(ADDR_STATUS, 32'h18, "status after power-on");
		rd(ADDR_POWER_RESET_CAUSE, 32'h0, "power_reset_cause after power-on");
		rd(ADDR_SEQ, 32'h08, "state in delay");
		chk("periph_reset in delay", 32'h1, {31'h0, periph_reset});
		rel(n);
		chk("core_hold released", 32'h0, {31'h0, core_hold});
		chk("periph_reset released", 32'h0, {31'h0, periph_reset});
	endtask : t_power_on

	task automatic t_table();
		rts_osc_mode_t m[5] = '{RTS_XT, RTS_LP, RTS_HS, RTS_RC, RTS_RC};
		logic en[5] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
		int ex;
		for (int i = 0; i < 5; i++) begin
			por(m[i], en[i], 1'h0);
			rel(n);
			ex = (en[i] ? 0 : PW) + ((m[i] != RTS_RC) ? OSC : 0);
			rng("time-out length", ex - 4, ex + 16, n);
		end
	endtask : t_table

	task automatic t_regs();
		logic [31:0] r;
		logic e;
		wr(ADDR_STATUS, 32'h0);
		rd(ADDR_STATUS, 32'h18, "status flags read-only");
		wr(ADDR_STATUS, 32'hE7);
		rd(ADDR_STATUS, 32'hFF, "status write");
		wr(ADDR_POWER_RESET_CAUSE, 32'h3);
		rd(ADDR_POWER_RESET_CAUSE, 32'h3, "power_reset_cause software set");
		wr(ADDR_SEQ, 32'hFF);
		rd(ADDR_SEQ, 32'h10, "state run");
		apb(1'h0, 12'h010, 32'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
	endtask : t_regs

	task automatic t_clear();
		por(RTS_RC, 1'h0, 1'h0);
		clr_req <= 1'h1;
		tick(PW + 300);
		chk("hold past time-outs", 32'h1, {31'h0, core_hold});
		clr_req <= 1'h0;
		rel(n);
		rng("start after pin high", 2, 8, n);
		wr(ADDR_STATUS, 32'hE0);
		clr_req <= 1'h1;
		@(posedge pclk);
		clr_req <= 1'h0;
		stay(20, 1'h0, "glitch ignored");
		clr_req <= 1'h1;
		tick(10);
		clr_req <= 1'h0;
		rel(n);
		rd(ADDR_STATUS, 32'h18, "status after run clear");
	endtask : t_clear

	task automatic t_brown();
		por(RTS_RC, 1'h1, 1'h0);
		rel(n);
		low_req <= 1'h1;
		stay(2500, 1'h0, "brown-out disabled");
		low_req <= 1'h0;
		por(RTS_RC, 1'h1, 1'h1);
		rel(n);
		rng("forced delay", PW - 4, PW + 16, n);
		wr(ADDR_POWER_RESET_CAUSE, 32'h3);
		low_req <= 1'h1;
		stay(1000, 1'h0, "short dip ignored");
		low_req <= 1'h0;
		tick(4);
		low_req <= 1'h1;
		tick(2100);
		chk("brown-out hold", 32'h1, {31'h0, core_hold});
		stay(400, 1'h1, "hold while low");
		low_req <= 1'h0;
		tick(100);
		low_req <= 1'h1;
		tick(2200);
		low_req <= 1'h0;
		rel(n);
		rng("restarted delay", PW - 4, PW + 16, n);
		rd(ADDR_POWER_RESET_CAUSE, 32'h2, "power_reset_cause after brown-out");
		rd(ADDR_STATUS, 32'h18, "status after brown-out");
	endtask : t_brown

	task automatic t_wake();
		pulse(3'h1);
		rd(ADDR_STATUS, 32'h08, "status watchdog reset");
		rd(ADDR_POWER_RESET_CAUSE, 32'h2, "power_reset_cause watchdog reset");
		chk("pc after reset", 32'h0, {19'h0, pc_start});
		pulse(3'h2);
		rd(ADDR_STATUS, 32'h10, "status asleep");
		pulse(3'h1);
		chk("pc watchdog wake", 32'h124, {19'h0, pc_start});
		chk("periph_reset on wake", 32'h0, {31'h0, periph_reset});
		chk("no hold on rc wake", 32'h0, {31'h0, core_hold});
		rd(ADDR_STATUS, 32'h00, "status watchdog wake");
		global_irq_enable <= 1'h1;
		pulse(3'h2);
		pulse(3'h4);
		chk("pc irq vector", 32'h4, {19'h0, pc_start});
		rd(ADDR_STATUS, 32'h10, "status irq wake");
		pulse(3'h2);
		clr_req <= 1'h1;
		tick(10);
		clr_req <= 1'h0;
		rel(n);
		rd(ADDR_STATUS, 32'h10, "status sleep clear");
		chk("pc after sleep clear", 32'h0, {19'h0, pc_start});
	endtask : t_wake

	initial begin
		tick(12);
		presetn <= 1'h1;
		t_power_on();
		t_table();
		t_regs();
		t_clear();
		t_brown();
		t_wake();
		print_verdict();
	end

	// the whole sequence needs about 43000 cycles
	initial begin
		tick(80000);
		err_count++;
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
